/* File: hdl/blank_timer.sv */
// Purpose: digital blanking window counted in chopping oscillator cycles
// Assumes: i_tick is a one-cycle pulse per oscillator cycle
// Notes: a restart during a running window starts the count from zero again
`timescale 1ns/100ps
`default_nettype none
module blank_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_enable, // low drops any running window at once
  input wire logic i_start,  // one-cycle request to open a window
  input wire logic i_tick,   // oscillator cycle enable
  // status
  output logic o_active,     // window running
  output logic o_done        // one-cycle pulse when a window runs out
);

  logic [2:0] cnt_q; // oscillator cycles seen in this window
  logic active_q;    // window running
  logic done_q;      // end of window marker

  // window counter; start wins over a tick in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_enable) begin
      cnt_q <= 3'h0;
      active_q <= 1'b0;
    end else if (i_start) begin
      cnt_q <= 3'h0;
      active_q <= 1'b1;
    end else if (active_q && i_tick) begin // time scales with the oscillator
      if (cnt_q == motor_blank_pkg::BLANK_TICKS - 3'h1) begin
        active_q <= 1'b0;
      end
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // end pulse, only for a window that ran its full length
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_enable) begin
      done_q <= 1'b0;
    end else begin
      done_q <= active_q && i_tick && !i_start && (cnt_q == motor_blank_pkg::BLANK_TICKS - 3'h1);
    end
  end

  assign o_active = active_q;
  assign o_done = done_q;

endmodule : blank_timer
`default_nettype wire

/* File: hdl/dc_motor_blanking_decay_start.sv */
// Purpose: blanking and mixed decay sequencing for one brushed DC bridge channel
// Assumes: inputs synchronous to i_clk; i_chop_oscillator pulses once per oscillator cycle
// Notes: the bridge state output selects charge, slow or fast decay for the power stage
`timescale 1ns/100ps
`default_nettype none
module dc_motor_blanking_decay_start (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // mode and run control
  input wire logic i_dc_mode,            // high selects brushed DC motor mode
  input wire logic i_run,                // high while the channel regulates
  // timing and sensing
  input wire logic i_chop_oscillator,    // one-cycle pulse per oscillator cycle
  input wire logic i_phase,              // externally driven phase level
  input wire logic i_current_reached,    // raw current sense comparator
  // status toward the power stage
  output logic [1:0] o_bridge_state,     // current drive state
  output logic o_blanking_interval,      // blanking window running
  output logic o_current_reached_flag    // comparator result after blanking
);

  motor_blank_pkg::bridge_state_t state_q; // drive state
  motor_blank_pkg::bridge_state_t state_d; // next drive state
  logic [3:0] per_q;       // oscillator cycle index within the period
  logic phase_q;           // phase input seen last cycle
  logic phase_edge;        // phase input changed this cycle
  logic charge_start;      // a charge phase begins next cycle
  logic blank_start;       // open a blanking window
  logic blank_active;      // window running
  logic blank_done;        // window ran out last cycle
  logic reached_ok;        // comparator accepted this cycle
  logic reached_q;         // registered accepted comparator
  logic period_end;        // last oscillator cycle of the period ends now

  // true on the oscillator cycle that closes the slot just before fast decay
  function automatic logic fast_point(input logic tick, input logic [3:0] idx);
    fast_point = tick && (idx == motor_blank_pkg::FAST_START_IDX - 4'h1);
  endfunction : fast_point

  // phase input history for change detection
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= i_phase;
    end
  end

  assign phase_edge = i_phase ^ phase_q;

  // a charge phase begins when the next state is charge and the current is not
  assign charge_start = (state_d == motor_blank_pkg::ST_CHARGE) && (state_q != motor_blank_pkg::ST_CHARGE);

  // phase change or charge start open a window, only in DC mode
  assign blank_start = i_dc_mode && (phase_edge || charge_start);

  // blanking window counter
  blank_timer u_blank (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_enable(i_dc_mode), // outside DC mode no window exists
    .i_start(blank_start),
    .i_tick(i_chop_oscillator),
    .o_active(blank_active),
    .o_done(blank_done)
  );

  // comparator is masked while switching noise may still ring
  assign reached_ok = i_current_reached && !blank_active;

  assign period_end = i_chop_oscillator && (per_q == motor_blank_pkg::PERIOD_LAST_IDX);

  // period index; restarts whenever the channel begins regulating
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_run) begin
      per_q <= 4'h0;
    end else if (state_q == motor_blank_pkg::ST_IDLE) begin
      per_q <= 4'h0;
    end else if (i_chop_oscillator) begin
      per_q <= per_q + 4'h1; // wraps at the period length of 16
    end
  end

  // the timer's end pulse already marks the first unmasked cycle after the window;
  // a further register here would hand that cycle to the slow decay branch first,
  // so the skip decision reads the end pulse directly

  // mixed decay sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      motor_blank_pkg::ST_IDLE: begin
        // operation always starts in the mixed decay scheme
        if (i_run) begin
          state_d = motor_blank_pkg::ST_CHARGE;
        end
      end
      motor_blank_pkg::ST_CHARGE: begin
        if (blank_active && i_dc_mode) begin
          // forced charge while the window runs
          state_d = motor_blank_pkg::ST_CHARGE;
        end else if (reached_ok && blank_done) begin
          // already at target when the window ends, skip slow decay
          state_d = motor_blank_pkg::ST_FAST;
        end else if (reached_ok) begin
          state_d = motor_blank_pkg::ST_SLOW;
        end else if (fast_point(i_chop_oscillator, per_q)) begin
          // target never reached; the fast share still starts on time
          state_d = motor_blank_pkg::ST_FAST;
        end
      end
      motor_blank_pkg::ST_SLOW: begin
        // 37.5 percent of the period is kept for fast decay
        if (fast_point(i_chop_oscillator, per_q)) begin
          state_d = motor_blank_pkg::ST_FAST;
        end
      end
      motor_blank_pkg::ST_FAST: begin
        // from fast decay a new period begins with charge
        if (period_end) begin
          state_d = motor_blank_pkg::ST_CHARGE;
        end
      end
      default: begin
        state_d = motor_blank_pkg::ST_IDLE;
      end
    endcase
    if (!i_run) begin
      state_d = motor_blank_pkg::ST_IDLE;
    end
  end

  // drive state register, updated automatically every cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= motor_blank_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // accepted comparator, registered for the output
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      reached_q <= 1'b0;
    end else begin
      reached_q <= reached_ok;
    end
  end

  assign o_bridge_state = state_q;
  assign o_blanking_interval = blank_active;
  assign o_current_reached_flag = reached_q;

  // checks next to the logic they guard
  property p_phase_blank;
    @(posedge i_clk) disable iff (i_srst) (phase_edge && i_dc_mode) |=> o_blanking_interval;
  endproperty
  a_phase_blank: assert property (p_phase_blank) else $error("no blanking after phase change");

  property p_charge_blank;
    @(posedge i_clk) disable iff (i_srst)
      (i_dc_mode && state_q != motor_blank_pkg::ST_CHARGE) ##1 (i_dc_mode && state_q == motor_blank_pkg::ST_CHARGE)
      |-> o_blanking_interval;
  endproperty
  a_charge_blank: assert property (p_charge_blank) else $error("no blanking at charge start");

  property p_mode_gate;
    @(posedge i_clk) disable iff (i_srst) !i_dc_mode |=> !o_blanking_interval;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("blanking outside DC mode");

  property p_fast_share;
    @(posedge i_clk) disable iff (i_srst)
      (i_run && state_q == motor_blank_pkg::ST_SLOW && i_chop_oscillator && per_q == 4'h9)
      |=> (o_bridge_state == 2'h3 && per_q == 4'hA);
  endproperty
  a_fast_share: assert property (p_fast_share) else $error("fast decay not at 37.5 percent point");

  property p_forced_charge;
    @(posedge i_clk) disable iff (i_srst)
      (i_run && i_dc_mode && o_blanking_interval && state_q == motor_blank_pkg::ST_CHARGE)
      |=> o_bridge_state == 2'h1;
  endproperty
  a_forced_charge: assert property (p_forced_charge) else $error("charge left during blanking");

  property p_skip_slow;
    @(posedge i_clk) disable iff (i_srst)
      (i_run && blank_done && state_q == motor_blank_pkg::ST_CHARGE && reached_ok) |=> o_bridge_state == 2'h3;
  endproperty
  a_skip_slow: assert property (p_skip_slow) else $error("slow decay not skipped at window end");

  property p_blank_osc;
    @(posedge i_clk) disable iff (i_srst)
      (o_blanking_interval && !i_chop_oscillator && i_dc_mode) |=> o_blanking_interval;
  endproperty
  a_blank_osc: assert property (p_blank_osc) else $error("blanking ended without oscillator cycle");

  property p_decay_order;
    @(posedge i_clk) disable iff (i_srst)
      (state_q == motor_blank_pkg::ST_SLOW) |=> (o_bridge_state == 2'h2 || o_bridge_state == 2'h3 || !$past(i_run));
  endproperty
  a_decay_order: assert property (p_decay_order) else $error("slow decay left out of order");

  property p_period_charge;
    @(posedge i_clk) disable iff (i_srst)
      (i_run && state_q == motor_blank_pkg::ST_FAST && period_end) |=> (o_bridge_state == 2'h1 && per_q == 4'h0);
  endproperty
  a_period_charge: assert property (p_period_charge) else $error("no charge at period start");

  property p_mask;
    @(posedge i_clk) disable iff (i_srst) o_blanking_interval |=> !o_current_reached_flag;
  endproperty
  a_mask: assert property (p_mask) else $error("comparator used during blanking");

endmodule : dc_motor_blanking_decay_start
`default_nettype wire

/* File: hdl/motor_blank_pkg.sv */
// Purpose: shared constants for the brushed DC blanking and decay sequencer
// Assumes: one 125 MHz clock; oscillator cycles arrive as one-cycle enable pulses
// Notes: all counts are in chopping oscillator cycles, not in system clocks
package motor_blank_pkg;

  // bridge drive states, binary codes written out
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0, // bridge off, not regulating
    ST_CHARGE = 2'h1, // drive current up
    ST_SLOW   = 2'h2, // short brake, current decays slowly
    ST_FAST   = 2'h3  // reverse drive, current decays fast
  } bridge_state_t;

  // system clock period in ns, kept for reference of the enable rate
  localparam int unsigned CLK_PERIOD_NS = 8;

  // blanking window length in oscillator cycles
  localparam logic [2:0] BLANK_TICKS = 3'h4;

  // one chopping period in oscillator cycles
  localparam logic [4:0] CHOP_PERIOD_TICKS = 5'h10;

  // mixed decay fast share, 37.5 percent of the period, as thousandths
  localparam int unsigned FAST_SHARE_PERMILLE = 375;

  // fast decay length in oscillator cycles, derived from the share
  localparam logic [4:0] FAST_TICKS = 5'((32'(CHOP_PERIOD_TICKS) * FAST_SHARE_PERMILLE) / 1000);

  // oscillator cycle index at which fast decay is forced
  localparam logic [3:0] FAST_START_IDX = 4'(CHOP_PERIOD_TICKS - FAST_TICKS);

  // last oscillator cycle index of a period
  localparam logic [3:0] PERIOD_LAST_IDX = 4'(CHOP_PERIOD_TICKS - 5'h01);

endpackage : motor_blank_pkg

/* File: verification/pwm_ctrl_model.sv */
// Purpose: external pwm controller model driving the phase level and the oscillator pulses
// Assumes: i_div of 2 or more clocks per oscillator cycle
// Notes: outputs move 1 ns after the edge that decides them
`timescale 1ns/100ps
`default_nettype none
module pwm_ctrl_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control from the bench
  input wire logic [7:0] i_div, // clocks per oscillator cycle
  input wire logic i_toggle,    // flip the phase level
  // toward the block
  output logic o_osc,
  output logic o_phase
);
  logic [7:0] cnt_q; // position inside one oscillator cycle; set by the reset the bench holds at start

  // values are taken at the edge and shown after a delay, so the block never races them
  always @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q <= 8'h00;
      o_osc <= #1 1'b0;
      o_phase <= #1 1'b0;
    end else begin
      cnt_q <= (cnt_q >= i_div - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      o_osc <= #1 (cnt_q == i_div - 8'h01); // one clock wide pulse
      if (i_toggle) begin
        o_phase <= #1 ~o_phase; // level change between brake and charge
      end
    end
  end
endmodule : pwm_ctrl_model
`default_nettype wire

/* File: verification/tb_dc_motor_blanking_decay_start.sv */
// Purpose: self-checking bench for blanking and decay start sequencing
// Assumes: 125 MHz clock, inputs driven 1 ns after the rising edge
// Notes: oscillator pulses are counted at each edge to place decisions in the period
`timescale 1ns/100ps
`default_nettype none
module tb_dc_motor_blanking_decay_start;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic dc_mode = 1'b0;
  logic run = 1'b0;
  logic cur = 1'b0;
  logic tog = 1'b0;
  logic [7:0] div = 8'h04;
  logic osc;
  logic phase;
  logic [1:0] state;
  logic blank;
  logic flag;
  int num_errors = 0;
  int n_checks = 0;
  int osc_cnt = 0; // oscillator pulses seen so far
  int s0;
  int i;

  always #4 clk = ~clk;

  // count pulses as the block samples them
  always @(posedge clk) begin
    if (osc) osc_cnt = osc_cnt + 1;
  end

  pwm_ctrl_model u_pwm_ctrl_model (.i_clk(clk), .i_srst(srst), .i_div(div), .i_toggle(tog),
    .o_osc(osc), .o_phase(phase));

  dc_motor_blanking_decay_start u_dc_motor_blanking_decay_start (.i_clk(clk), .i_srst(srst),
    .i_dc_mode(dc_mode), .i_run(run), .i_chop_oscillator(osc), .i_phase(phase),
    .i_current_reached(cur), .o_bridge_state(state), .o_blanking_interval(blank),
    .o_current_reached_flag(flag));

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  // bounded waits; running out counts a mismatch and ends the run
  task automatic wait_state(input logic [1:0] exp, input int lim);
    int k;
    for (k = 0; k < lim && state !== exp; k++) tick();
    if (state !== exp) begin
      $display("[ERR] wait for state %0h ran out", exp);
      num_errors++;
      report_and_stop();
    end
  endtask : wait_state

  task automatic wait_blank(input logic exp, input int lim);
    int k;
    for (k = 0; k < lim && blank !== exp; k++) tick();
    if (blank !== exp) begin
      $display("[ERR] wait for blanking %0h ran out", exp);
      num_errors++;
      report_and_stop();
    end
  endtask : wait_blank

  // reset for 20 clocks, then start regulating
  task automatic start(input logic dc, input logic [7:0] d, input logic c);
    srst = 1'b1;
    run = 1'b0;
    dc_mode = dc;
    div = d;
    cur = c;
    repeat (20) tick();
    srst = 1'b0;
    run = 1'b1;
    tick();
    s0 = osc_cnt;
  endtask : start

  // reached already during the forced charge window
  task automatic sc_reached_in_window();
    start(1'b1, 8'h04, 1'b1);
    chk("start state", motor_blank_pkg::ST_CHARGE, state);
    for (i = 0; i < 40 && blank === 1'b1; i++) begin
      // the flag lags one cycle: the first window cycle still shows the idle sample
      chk("flag in window", (i == 0) ? 8'h01 : 8'h00, flag);
      chk("state in window", motor_blank_pkg::ST_CHARGE, state);
      tick();
    end
    wait_state(motor_blank_pkg::ST_FAST, 3);
  endtask : sc_reached_in_window

  // full period: charge, slow on reached, fast at index 10, charge at wrap
  task automatic sc_period_order();
    start(1'b1, 8'h04, 1'b0);
    chk("blank at charge", 1'b1, blank);
    wait_blank(1'b0, 100);
    chk("window pulses", 8'h04, 8'(osc_cnt - s0));
    repeat (2) tick();
    cur = 1'b1;
    wait_state(motor_blank_pkg::ST_SLOW, 3);
    chk("flag outside window", 1'b1, flag);
    cur = 1'b0;
    wait_state(motor_blank_pkg::ST_FAST, 100);
    chk("fast start index", 8'h0A, 8'(osc_cnt - s0));
    wait_state(motor_blank_pkg::ST_CHARGE, 100);
    chk("period length", 8'h10, 8'(osc_cnt - s0));
    chk("blank at wrap", 1'b1, blank);
  endtask : sc_period_order

  // phase change mid period with a slower oscillator
  task automatic sc_phase_change();
    start(1'b1, 8'h08, 1'b0);
    wait_blank(1'b0, 100);
    repeat (3) tick();
    tog = 1'b1;
    tick();
    tog = 1'b0;
    wait_blank(1'b1, 3);
    s0 = osc_cnt;
    for (i = 0; i < 60 && blank === 1'b1; i++) tick();
    chk("phase window pulses", 8'h04, 8'(osc_cnt - s0));
    chk("window scales", 1'b1, i >= 24);
  endtask : sc_phase_change

  // other mode: no window from start, wrap or phase change
  task automatic sc_other_mode();
    int seen;
    seen = 0;
    start(1'b0, 8'h04, 1'b0);
    tog = 1'b1;
    tick();
    tog = 1'b0;
    for (i = 0; i < 90; i++) begin
      if (blank !== 1'b0) seen = 1;
      tick();
    end
    chk("blank in other mode", 1'b0, seen[0]);
  endtask : sc_other_mode

  initial begin
    sc_reached_in_window();
    sc_period_order();
    sc_phase_change();
    sc_other_mode();
    report_and_stop();
  end
endmodule : tb_dc_motor_blanking_decay_start
`default_nettype wire
